// >>> wiper_pkg.sv
package wiper_pkg;

  localparam int DATA_W        = 8;
  localparam int ADDR_W        = 2;
  localparam int FRAME_BITS    = 1 + ADDR_W + DATA_W;
  localparam int CLK_PERIOD_NS = 8;

  localparam int CS_FILTER_NS  = 90;
  localparam int CS_FILTER_CYC =
    (CS_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int STORE_BUSY_NS  = 5000000;
  localparam int STORE_BUSY_CYC = STORE_BUSY_NS / CLK_PERIOD_NS;

  localparam int DISCARD_SCLK = 2;
  localparam int GAP_SCLK     = 2;

  localparam int SCLK_HALF_NS  = 500;
  localparam int SCLK_HALF_CYC =
    (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_LOW_NS     = 150;
  localparam int CS_LOW_CYC    =
    (CS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int READ_FIRST_EDGE = 1 + ADDR_W;

  localparam logic [7:0] NV_RESET_FIRST  = 8'h80;
  localparam logic [7:0] NV_RESET_SECOND = 8'h80;
  localparam logic [1:0] ADDR_FIRST      = 2'h0;
  localparam logic [1:0] ADDR_SECOND     = 2'h1;

  typedef enum logic [2:0] {
    D_LOAD, D_IDLE, D_ADDR, D_DATA, D_HOLD, D_BUSY
  } dev_state_e;

  typedef enum logic [2:0] {
    H_IDLE, H_SEL, H_LOW, H_HIGH, H_TAIL, H_DESEL
  } host_state_e;

endpackage : wiper_pkg

// >>> wiper_link_if.sv
`timescale 1ns/100ps
interface wiper_link_if;
  logic select;
  logic sclk;
  logic serial_in;
  logic store_request;
  logic serial_out;
  logic serial_out_oe;
  logic store_ready_flag;
  logic data_line;

  // The shared return line idles high when no device drives it.
  assign data_line = serial_out_oe ? serial_out : 1'b1;

  modport device (
    input  select,
    input  sclk,
    input  serial_in,
    input  store_request,
    output serial_out,
    output serial_out_oe,
    output store_ready_flag
  );

  modport host (
    output select,
    output sclk,
    output serial_in,
    output store_request,
    input  data_line,
    input  store_ready_flag
  );
endinterface : wiper_link_if

// >>> wiper_device.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Fields travel least significant bit first.
// - Frames begin only on a high start bit.
// - Sample input, advance output on rising clock.
// - Host leaves two clocks between frames.
// - Serial output floats when unused; here it is driven whenever select is high and no store is busy.
// - Select low ignores transfers.
// - Select fall reloads outputs, floats output.
// - Select is filtered against short glitches.
// - Host keeps clock running during store.
// - Power-up loads wipers without serial clock.
// - Store request holds ready low until done.
// - Busy store ignores input, emits nothing.
// - Low supply keeps ready high, store fails.
// - Readback follows start and address bits.
// - Address zero first, one second output.
// - Each channel holds a retained 8-bit setting.
// - Channels written independently, store optional.
// - Frame is start, address, data; apply next.
// - Store request set up before post-frame edge.
// - Unstored value discarded two clocks later.
// - Early deselect reloads wiper after readback.
module wiper_device #(
  parameter int BUSY_CYCLES = wiper_pkg::STORE_BUSY_CYC
) (
  input  wire logic         clk,
  input  wire logic         srst,
  wiper_link_if.device      link,
  input  wire logic         supply_low,
  output logic [7:0]        first_output,
  output logic [7:0]        second_output
);

  localparam int FLT_W  = $clog2(wiper_pkg::CS_FILTER_CYC + 1);
  localparam int BUSY_W = $clog2(BUSY_CYCLES + 1);

  logic [3:0]             sync1;
  logic [3:0]             sync2;
  logic                   sel_f;
  logic                   sel_d;
  logic                   sclk_d;
  logic [FLT_W-1:0]       flt_cnt;
  wiper_pkg::dev_state_e  state;
  logic [3:0]             bit_cnt;
  logic [1:0]             addr;
  logic [7:0]             data_in;
  logic [7:0]             out_sr;
  logic                   apply;
  logic [BUSY_W-1:0]      busy_cnt;
  logic [7:0]             nv_first;
  logic [7:0]             nv_second;
  logic                   ready;

  logic sel_raw;
  logic sclk_s;
  logic sin_s;
  logic store_request_s;
  logic rise;
  logic sel_fall;
  logic frame_done;
  logic store_go;
  logic busy_done;
  logic [1:0] read_addr;

  assign sel_raw = sync2[3];
  assign sclk_s  = sync2[2];
  assign sin_s   = sync2[1];
  assign store_request_s  = sync2[0];

  // All link inputs come from another clock and pass two flip-flops.
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end else begin
      sync1 <= {link.select, link.sclk, link.serial_in, link.store_request};
      sync2 <= sync1;
    end
  end

  // Select changes only after staying at its new level for the window.
  always_ff @(posedge clk) begin
    if (srst) begin
      sel_f   <= 1'b0;
      flt_cnt <= '0;
    end else if (sel_raw == sel_f) begin
      flt_cnt <= '0;
    end else if (flt_cnt == FLT_W'(wiper_pkg::CS_FILTER_CYC - 1)) begin
      sel_f   <= sel_raw;
      flt_cnt <= '0;
    end else begin
      flt_cnt <= flt_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sel_d  <= 1'b0;
      sclk_d <= 1'b0;
    end else begin
      sel_d  <= sel_f;
      sclk_d <= sclk_s;
    end
  end

  assign sel_fall   = sel_d & ~sel_f;
  assign rise       = sclk_s & ~sclk_d & sel_f;
  assign frame_done = (state == wiper_pkg::D_DATA) && rise &&
                      (bit_cnt == 4'(wiper_pkg::DATA_W - 1));
  // A store is taken at the last data edge or before the discard ends.
  assign store_go   = (frame_done || (state == wiper_pkg::D_HOLD && sel_f))
                      && store_request_s && !supply_low;
  assign busy_done  = (state == wiper_pkg::D_BUSY) &&
                      (busy_cnt == BUSY_W'(BUSY_CYCLES - 1));
  assign read_addr  = {sin_s, addr[0]};

  always_ff @(posedge clk) begin
    if (srst) begin
      state   <= wiper_pkg::D_LOAD;
      bit_cnt <= 4'h0;
      addr    <= 2'h0;
      data_in <= 8'h00;
    end else begin
      case (state)
        wiper_pkg::D_LOAD: begin
          state <= wiper_pkg::D_IDLE;
        end
        wiper_pkg::D_BUSY: begin
          if (busy_done) begin
            state <= wiper_pkg::D_IDLE;
          end
        end
        wiper_pkg::D_IDLE: begin
          bit_cnt <= 4'h0;
          if (rise && sin_s) begin
            state <= wiper_pkg::D_ADDR;
          end
        end
        wiper_pkg::D_ADDR: begin
          if (!sel_f) begin
            state <= wiper_pkg::D_IDLE;
          end else if (rise) begin
            addr[bit_cnt[0]] <= sin_s;
            if (bit_cnt == 4'(wiper_pkg::ADDR_W - 1)) begin
              state   <= wiper_pkg::D_DATA;
              bit_cnt <= 4'h0;
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        wiper_pkg::D_DATA: begin
          if (!sel_f) begin
            state <= wiper_pkg::D_IDLE;
          end else if (rise) begin
            data_in[bit_cnt[2:0]] <= sin_s;
            bit_cnt <= bit_cnt + 4'h1;
            if (frame_done) begin
              bit_cnt <= 4'h0;
              state   <= store_go ? wiper_pkg::D_BUSY : wiper_pkg::D_HOLD;
            end
          end
        end
        wiper_pkg::D_HOLD: begin
          if (!sel_f) begin
            state <= wiper_pkg::D_IDLE;
          end else if (store_go) begin
            state <= wiper_pkg::D_BUSY;
          end else if (rise) begin
            if (bit_cnt == 4'(wiper_pkg::DISCARD_SCLK - 1)) begin
              state <= wiper_pkg::D_IDLE;
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        default: begin
          state <= wiper_pkg::D_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      apply <= 1'b0;
    end else begin
      apply <= frame_done;
    end
  end

  // Deselect and power-up reload win over a pending update.
  always_ff @(posedge clk) begin
    if (srst) begin
      first_output  <= 8'h00;
      second_output <= 8'h00;
    end else if (state == wiper_pkg::D_LOAD || sel_fall) begin
      first_output  <= nv_first;
      second_output <= nv_second;
    end else if (apply) begin
      if (addr == wiper_pkg::ADDR_FIRST) begin
        first_output <= data_in;
      end else if (addr == wiper_pkg::ADDR_SECOND) begin
        second_output <= data_in;
      end
    end
  end

  // Retained settings, written only at the end of a store cycle.
  always_ff @(posedge clk) begin
    if (srst) begin
      nv_first  <= wiper_pkg::NV_RESET_FIRST;
      nv_second <= wiper_pkg::NV_RESET_SECOND;
    end else if (busy_done) begin
      if (addr == wiper_pkg::ADDR_FIRST) begin
        nv_first <= data_in;
      end else if (addr == wiper_pkg::ADDR_SECOND) begin
        nv_second <= data_in;
      end
    end
  end

  // The store cycle is timed on the system clock.
  always_ff @(posedge clk) begin
    if (srst || state != wiper_pkg::D_BUSY) begin
      busy_cnt <= '0;
    end else begin
      busy_cnt <= busy_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ready <= 1'b1;
    end else begin
      ready <= !(store_go || (state == wiper_pkg::D_BUSY && !busy_done));
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      out_sr <= 8'h00;
    end else if (state == wiper_pkg::D_ADDR && rise &&
                 bit_cnt == 4'(wiper_pkg::ADDR_W - 1)) begin
      if (read_addr == wiper_pkg::ADDR_FIRST) begin
        out_sr <= first_output;
      end else if (read_addr == wiper_pkg::ADDR_SECOND) begin
        out_sr <= second_output;
      end else begin
        out_sr <= 8'h00;
      end
    end else if (state == wiper_pkg::D_DATA && rise) begin
      out_sr <= {1'b0, out_sr[7:1]};
    end
  end

  assign link.serial_out       = out_sr[0];
  assign link.serial_out_oe    = sel_f &&
                                 (state != wiper_pkg::D_BUSY);
  assign link.store_ready_flag = ready;

endmodule : wiper_device

// >>> wiper_host.sv
`timescale 1ns/100ps
module wiper_host (
  input  wire logic        clk,
  input  wire logic        srst,
  wiper_link_if.host       link,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [1:0]  cmd_addr,
  input  wire logic [7:0]  cmd_data,
  input  wire logic        cmd_store,
  input  wire logic        cmd_read_only,
  input  wire logic        cmd_release,
  output logic             done,
  output logic [7:0]       rd_data,
  output logic             store_ok
);

  localparam int DIV_W = $clog2(wiper_pkg::SCLK_HALF_CYC + 1);

  logic [1:0]              line_sync;
  logic [1:0]              rdy_sync;
  logic [DIV_W-1:0]        div;
  wiper_pkg::host_state_e  state;
  logic [10:0]             frame_sr;
  logic [3:0]              edges;
  logic [1:0]              tail;
  logic                    store;
  logic                    read_only;
  logic                    release_sel;
  logic                    seen_busy;
  logic                    select;
  logic                    sclk;
  logic                    serial_in;
  logic                    store_request;
  logic                    tick;
  logic                    tail_end;

  assign tick = (div == DIV_W'(wiper_pkg::SCLK_HALF_CYC - 1));
  assign tail_end = (tail >= 2'(wiper_pkg::GAP_SCLK)) && !sclk &&
                    (!store || seen_busy == 1'b0 || rdy_sync[1]);

  always_ff @(posedge clk) begin
    if (srst) begin
      line_sync <= 2'h3;
      rdy_sync  <= 2'h3;
    end else begin
      line_sync <= {line_sync[0], link.data_line};
      rdy_sync  <= {rdy_sync[0], link.store_ready_flag};
    end
  end

  always_ff @(posedge clk) begin
    if (srst || state == wiper_pkg::H_IDLE || tick) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state         <= wiper_pkg::H_IDLE;
      frame_sr      <= 11'h000;
      edges         <= 4'h0;
      tail          <= 2'h0;
      store         <= 1'b0;
      read_only     <= 1'b0;
      release_sel   <= 1'b0;
      seen_busy     <= 1'b0;
      select        <= 1'b0;
      sclk          <= 1'b0;
      serial_in     <= 1'b0;
      store_request <= 1'b0;
      done          <= 1'b0;
      rd_data       <= 8'h00;
      store_ok      <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        wiper_pkg::H_IDLE: begin
          if (cmd_valid) begin
            frame_sr    <= {cmd_data, cmd_addr, 1'b1};
            serial_in   <= 1'b1;
            edges       <= 4'h0;
            tail        <= 2'h0;
            seen_busy   <= 1'b0;
            store       <= cmd_store;
            read_only   <= cmd_read_only;
            release_sel <= cmd_release | cmd_read_only;
            state       <= select ? wiper_pkg::H_LOW : wiper_pkg::H_SEL;
          end
        end
        wiper_pkg::H_SEL: begin
          select <= 1'b1;
          if (tick) begin
            state <= wiper_pkg::H_LOW;
          end
        end
        wiper_pkg::H_LOW: begin
          if (tick) begin
            if (edges >= 4'(wiper_pkg::READ_FIRST_EDGE)) begin
              rd_data <= {line_sync[1], rd_data[7:1]};
            end
            if (read_only && edges == 4'(wiper_pkg::FRAME_BITS - 1)) begin
              select <= 1'b0;
              done   <= 1'b1;
              state  <= wiper_pkg::H_DESEL;
            end else begin
              sclk  <= 1'b1;
              edges <= edges + 4'h1;
              state <= wiper_pkg::H_HIGH;
            end
          end
        end
        wiper_pkg::H_HIGH: begin
          if (tick) begin
            sclk <= 1'b0;
            if (edges == 4'h1 && store) begin
              store_request <= 1'b1;
            end
            if (edges == 4'(wiper_pkg::FRAME_BITS)) begin
              serial_in <= 1'b0;
              state     <= wiper_pkg::H_TAIL;
            end else begin
              frame_sr  <= {1'b0, frame_sr[10:1]};
              serial_in <= frame_sr[1];
              state     <= wiper_pkg::H_LOW;
            end
          end
        end
        wiper_pkg::H_TAIL: begin
          if (!rdy_sync[1]) begin
            seen_busy <= 1'b1;
          end
          if (tick) begin
            if (tail_end) begin
              store_request <= 1'b0;
              store_ok      <= store && seen_busy;
              done          <= 1'b1;
              select        <= select & ~release_sel;
              state         <= release_sel ? wiper_pkg::H_DESEL
                                           : wiper_pkg::H_IDLE;
            end else begin
              sclk <= ~sclk;
              if (!sclk && tail != 2'h3) begin
                tail <= tail + 2'h1;
              end
            end
          end
        end
        wiper_pkg::H_DESEL: begin
          if (tick) begin
            state <= wiper_pkg::H_IDLE;
          end
        end
        default: begin
          state <= wiper_pkg::H_IDLE;
        end
      endcase
    end
  end

  assign cmd_ready          = (state == wiper_pkg::H_IDLE);
  assign link.select        = select;
  assign link.sclk          = sclk;
  assign link.serial_in     = serial_in;
  assign link.store_request = store_request;

endmodule : wiper_host

// >>> wiper_link_sva.sv
`timescale 1ns/100ps
module wiper_link_sva #(
  parameter int BUSY_CYCLES = 200
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic select,
  input wire logic sclk,
  input wire logic serial_in,
  input wire logic store_request,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic store_ready_flag,
  input wire logic data_line
);
  logic [31:0] busy_cnt;
  logic [3:0]  since_rise;
  logic [3:0]  rises;
  logic [4:0]  low_cnt;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // Counts the cycles of one busy phase.
  always_ff @(posedge clk) begin
    if (srst || store_ready_flag) busy_cnt <= '0;
    else busy_cnt <= busy_cnt + 32'h1;
  end

  // Counts system clocks since the last link clock rise.
  always_ff @(posedge clk) begin
    if (srst || $rose(sclk)) since_rise <= '0;
    else if (since_rise != 4'hF) since_rise <= since_rise + 4'h1;
  end

  // Counts link clock rises since select went high.
  always_ff @(posedge clk) begin
    if (srst || !select) rises <= '0;
    else if ($rose(sclk) && rises != 4'hF) rises <= rises + 4'h1;
  end

  // Counts cycles of select low.
  always_ff @(posedge clk) begin
    if (srst || select) low_cnt <= '0;
    else if (low_cnt != 5'h1F) low_cnt <= low_cnt + 5'h1;
  end

  a_start_bit_high:
    assert property ($rose(sclk) && select && rises == 4'h0 |-> serial_in)
    else $error("first bit of a frame is not high");
  a_busy_needs_request:
    assert property ($fell(store_ready_flag)
                     |-> store_request || $past(store_request))
    else $error("busy without store request");
  a_busy_length:
    assert property ($rose(store_ready_flag) |-> busy_cnt == BUSY_CYCLES)
    else $error("busy phase has wrong length");
  a_busy_quiet_out:
    assert property (!store_ready_flag |-> !serial_out_oe)
    else $error("output driven while busy");
  a_oe_needs_select:
    assert property ($rose(serial_out_oe) |-> select)
    else $error("output enabled without select");
  a_deselect_float:
    assert property ($fell(select) |-> ##[1:20] !serial_out_oe)
    else $error("output still driven after deselect");
  a_idle_float:
    assert property (low_cnt >= 5'h14 |-> !serial_out_oe && data_line)
    else $error("return line not released while idle");
  a_out_on_rise:
    assert property (serial_out_oe && $past(serial_out_oe)
                     && $changed(serial_out) |-> since_rise <= 4'hA)
    else $error("output bit moved away from a clock rise");
  a_store_in_frame:
    assert property ($rose(store_request) |-> select)
    else $error("store request outside a frame");
endmodule : wiper_link_sva

// >>> tb.sv
`timescale 1ns/100ps
module tb;
  localparam int BUSY = 200;
  localparam int SETTLE = wiper_pkg::CS_FILTER_CYC + 8;
  logic        clk;
  logic        srst;
  logic        supply_low;
  logic        cmd_valid;
  logic        cmd_ready;
  logic [1:0]  cmd_addr;
  logic [7:0]  cmd_data;
  logic        cmd_store;
  logic        cmd_read_only;
  logic        cmd_release;
  logic        done;
  logic [7:0]  rd_data;
  logic        store_ok;
  logic [7:0]  first_output;
  logic [7:0]  second_output;
  logic [10:0] bits;
  logic        sclk_q;
  int          nrise;
  int          n_fail;
  int          total_checks;

  wiper_link_if lk ();

  wiper_device #(.BUSY_CYCLES(BUSY)) i_wiper_device (
    .clk(clk), .srst(srst), .link(lk.device), .supply_low(supply_low),
    .first_output(first_output), .second_output(second_output));

  wiper_host i_wiper_host (
    .clk(clk), .srst(srst), .link(lk.host), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_store(cmd_store), .cmd_read_only(cmd_read_only),
    .cmd_release(cmd_release), .done(done), .rd_data(rd_data),
    .store_ok(store_ok));

  wiper_link_sva #(.BUSY_CYCLES(BUSY)) i_wiper_link_sva (
    .clk(clk), .srst(srst), .select(lk.select), .sclk(lk.sclk),
    .serial_in(lk.serial_in), .store_request(lk.store_request),
    .serial_out(lk.serial_out), .serial_out_oe(lk.serial_out_oe),
    .store_ready_flag(lk.store_ready_flag), .data_line(lk.data_line));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Captures the first eleven serial input bits (start, address, data) of each frame on the wire.
  always @(posedge clk) begin
    sclk_q <= lk.sclk;
    if (cmd_valid && cmd_ready) begin
      nrise <= 0;
    end else if (lk.select && lk.sclk && !sclk_q && nrise < 11) begin
      bits[nrise] <= lk.serial_in;
      nrise <= nrise + 1;
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    if (n_fail == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic xfer(input logic [1:0] a, input logic [7:0] d,
                      input logic st, input logic ro, input logic rel);
    @(posedge clk);
    cmd_valid     <= 1'b1;
    cmd_addr      <= a;
    cmd_data      <= d;
    cmd_store     <= st;
    cmd_read_only <= ro;
    cmd_release   <= rel;
    @(posedge clk);
    while (cmd_ready !== 1'b1) @(posedge clk);
    cmd_valid <= 1'b0;
    while (done !== 1'b1) @(posedge clk);
    if (!ro) begin
      check(bits[10:3], d);
      check({5'h00, bits[2:0]}, {5'h00, a, 1'b1});
    end
    repeat (SETTLE) @(posedge clk);
  endtask : xfer

  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    finish_test();
  end

  initial begin
    n_fail = 0;
    total_checks = 0;
    nrise = 0;
    srst = 1'b1;
    supply_low = 1'b0;
    cmd_valid = 1'b0;
    cmd_addr = 2'h0;
    cmd_data = 8'h00;
    cmd_store = 1'b0;
    cmd_read_only = 1'b0;
    cmd_release = 1'b0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    check(first_output, wiper_pkg::NV_RESET_FIRST);
    check(second_output, wiper_pkg::NV_RESET_SECOND);
    check({7'h00, lk.serial_out_oe}, 8'h00);
    xfer(wiper_pkg::ADDR_FIRST, 8'h35, 1'b0, 1'b0, 1'b0);
    check(first_output, 8'h35);
    check(second_output, 8'h80);
    check(rd_data, 8'h80);
    xfer(wiper_pkg::ADDR_SECOND, 8'hCA, 1'b0, 1'b0, 1'b0);
    check(second_output, 8'hCA);
    check(first_output, 8'h35);
    check(rd_data, 8'h80);
    xfer(wiper_pkg::ADDR_FIRST, 8'h00, 1'b0, 1'b1, 1'b0);
    check(rd_data, 8'h35);
    check(first_output, 8'h80);
    check(second_output, 8'h80);
    check({7'h00, lk.data_line}, 8'h01);
    xfer(wiper_pkg::ADDR_SECOND, 8'h5A, 1'b1, 1'b0, 1'b1);
    check({7'h00, store_ok}, 8'h01);
    check(second_output, 8'h5A);
    xfer(wiper_pkg::ADDR_FIRST, 8'h77, 1'b0, 1'b0, 1'b0);
    check(first_output, 8'h77);
    xfer(2'h2, 8'hAB, 1'b0, 1'b0, 1'b0);
    check(rd_data, 8'h00);
    check(first_output, 8'h77);
    check(second_output, 8'h5A);
    xfer(wiper_pkg::ADDR_FIRST, 8'h66, 1'b0, 1'b0, 1'b1);
    check(first_output, 8'h80);
    check(second_output, 8'h5A);
    supply_low <= 1'b1;
    xfer(wiper_pkg::ADDR_FIRST, 8'h12, 1'b1, 1'b0, 1'b1);
    check({7'h00, store_ok}, 8'h00);
    check(first_output, 8'h80);
    supply_low <= 1'b0;
    xfer(wiper_pkg::ADDR_SECOND, 8'h00, 1'b0, 1'b1, 1'b0);
    check(rd_data, 8'h5A);
    check(second_output, 8'h5A);
    finish_test();
  end
endmodule : tb
